/* File: pkg/codec_regs_pkg.sv */
/*
 * Shared constants and carrier types for the codec level-control, synthesiser
 * and input-routing control registers.
 * Assumes one clock, a synchronous active-high reset and 7-bit register addresses.
 */
package codec_regs_pkg;

    // ==========================================================================
    // Bus geometry.
    localparam int ADDR_W   = 7;
    localparam int DATA_W   = 16;
    localparam int FIELD_W  = 9;
    localparam int NUM_REGS = 10;
    localparam int IDX_W    = 4;

    typedef logic [FIELD_W-1:0] field_t;
    typedef logic [ADDR_W-1:0]  addr_t;

    // ==========================================================================
    // Register offsets.
    localparam addr_t LEVEL_TARGET_CTRL_ADDR   = 7'h21;
    localparam addr_t ALC_MODE_TIMING_ADDR     = 7'h22;
    localparam addr_t NOISE_GATE_CTRL_ADDR     = 7'h23;
    localparam addr_t PLL_CTRL_ADDR            = 7'h24;
    localparam addr_t PLL_FRAC_HIGH_ADDR       = 7'h25;
    localparam addr_t PLL_FRAC_MID_ADDR        = 7'h26;
    localparam addr_t PLL_FRAC_LOW_ADDR        = 7'h27;
    localparam addr_t ALC_ZERO_CROSS_CTRL_ADDR = 7'h2a;
    localparam addr_t INPUT_ROUTING_CTRL_ADDR  = 7'h2c;
    localparam addr_t INPUT_GAIN_CTRL_ADDR     = 7'h2d;

    // ==========================================================================
    // Register indices, in the order of the address table.
    localparam int IDX_LEVEL   = 0;
    localparam int IDX_TIMING  = 1;
    localparam int IDX_GATE    = 2;
    localparam int IDX_PLL     = 3;
    localparam int IDX_FRAC_HI = 4;
    localparam int IDX_FRAC_MD = 5;
    localparam int IDX_FRAC_LO = 6;
    localparam int IDX_ALC_ZC  = 7;
    localparam int IDX_ROUTING = 8;
    localparam int IDX_GAIN    = 9;

    localparam addr_t REG_ADDR [NUM_REGS] = '{
        LEVEL_TARGET_CTRL_ADDR, ALC_MODE_TIMING_ADDR, NOISE_GATE_CTRL_ADDR,
        PLL_CTRL_ADDR, PLL_FRAC_HIGH_ADDR, PLL_FRAC_MID_ADDR, PLL_FRAC_LOW_ADDR,
        ALC_ZERO_CROSS_CTRL_ADDR, INPUT_ROUTING_CTRL_ADDR, INPUT_GAIN_CTRL_ADDR};

    // Implemented bits of each register; all others are reserved.
    localparam field_t REG_MASK [NUM_REGS] = '{
        9'h00f, 9'h1ff, 9'h00f, 9'h0ff, 9'h03f,
        9'h1ff, 9'h1ff, 9'h002, 9'h10f, 9'h0c0};

    // Values after reset.
    localparam field_t REG_RESET [NUM_REGS] = '{
        9'h00b, 9'h032, 9'h000, 9'h04c, 9'h00c,
        9'h093, 9'h0e9, 9'h000, 9'h002, 9'h040};

    // ==========================================================================
    // Field positions.
    localparam int LOOP_MODE_BIT  = 8;
    localparam int RISE_LSB       = 4;
    localparam int GATE_EN_BIT    = 3;
    localparam int POWER_OFF_BIT  = 7;
    localparam int FRAC_EN_BIT    = 6;
    localparam int PRESCALE_LSB   = 4;
    localparam int LOOP_ZC_BIT    = 1;
    localparam int BIAS_SEL_BIT   = 8;
    localparam int AUX_MODE_BIT   = 3;
    localparam int AUX_TO_PGA_BIT = 2;
    localparam int MIC_NEG_BIT    = 1;
    localparam int MIC_POS_BIT    = 0;
    localparam int GAIN_ZC_BIT    = 7;
    localparam int GAIN_MUTE_BIT  = 6;

    // Open bounds of the legal integer ratio.
    localparam logic [3:0] RATIO_LOW_EXCL  = 4'h5;
    localparam logic [3:0] RATIO_HIGH_EXCL = 4'hd;

    // ==========================================================================
    // Carrier types.
    typedef struct packed {
        logic [3:0] level_target;
        logic       level_loop_mode;
        logic [3:0] gain_rise_time;
        logic [3:0] gain_fall_time;
        logic       gate_enable;
        logic [2:0] gate_threshold;
        logic       level_loop_zero_cross;
    } alc_cfg_s;

    typedef struct packed {
        logic        synth_power_off;
        logic        fractional_divide_enable;
        logic [1:0]  synth_input_prescale;
        logic [3:0]  synth_integer_ratio;
        logic [23:0] synth_fraction_ratio;
    } pll_cfg_s;

    typedef struct packed {
        logic mic_bias_level_select;
        logic aux_amp_mode;
        logic aux_to_gain_stage;
        logic mic_neg_to_gain_stage;
        logic mic_pos_to_gain_stage;
        logic input_gain_zero_cross;
        logic input_gain_mute;
    } input_cfg_s;

    // Reference conditioning: doubling, or a right shift by div_log2.
    typedef struct packed {
        logic       mult2;
        logic [1:0] div_log2;
    } prescale_s;

endpackage

/* File: tb/codec_alc_pll_input_regs_tb.sv */
/* Self-checking bench for the codec control register bank.
   Assumes the package and the bank's module are compiled first. */
`timescale 1ns/1ns
module codec_alc_pll_input_regs_tb;
    logic                       core_clk, reset, reg_wr_en, reg_rd_en;
    logic                       gain_vol_written, zero_cross_seen;
    codec_regs_pkg::addr_t      reg_addr;
    logic [15:0]                reg_wdata, reg_rdata;
    logic                       reg_rd_valid, synth_ratio_ok, gain_apply;
    codec_regs_pkg::alc_cfg_s   alc_cfg;
    codec_regs_pkg::pll_cfg_s   pll_cfg;
    codec_regs_pkg::input_cfg_s input_cfg;
    codec_regs_pkg::prescale_s  synth_prescale;
    int                         mismatches, cmp_count, cycles;
    logic [6:0]  atab [10] = '{7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h2a,
                               7'h2c, 7'h2d};
    logic [15:0] mtab [10] = '{16'h000f, 16'h01ff, 16'h000f, 16'h00ff, 16'h003f, 16'h01ff,
                               16'h01ff, 16'h0002, 16'h010f, 16'h00c0};
    logic [15:0] rtab [10] = '{16'h000b, 16'h0032, 16'h0000, 16'h004c, 16'h000c, 16'h0093,
                               16'h00e9, 16'h0000, 16'h0002, 16'h0040};
    codec_alc_pll_input_regs dut (.core_clk(core_clk), .reset(reset), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .gain_vol_written(gain_vol_written), .zero_cross_seen(zero_cross_seen),
        .alc_cfg(alc_cfg), .pll_cfg(pll_cfg), .input_cfg(input_cfg),
        .synth_prescale(synth_prescale), .synth_ratio_ok(synth_ratio_ok),
        .gain_apply(gain_apply));
    // ==========================================================================
    // Shared tasks.
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(logic [6:0] a, logic [15:0] d);
        @(negedge core_clk);
        reg_wr_en = 1'b1; reg_addr = a; reg_wdata = d;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd_check(logic [6:0] a, logic [15:0] exp);
        @(negedge core_clk);
        reg_rd_en = 1'b1; reg_addr = a;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        check("rd_valid", reg_rd_valid, 1);
        check("rdata", reg_rdata, exp);
    endtask
    // ==========================================================================
    // Scenarios.
    task automatic t_reset_values();
        for (int i = 0; i < 10; i++) rd_check(atab[i], rtab[i]);
        check("frac", pll_cfg.synth_fraction_ratio, 24'h31_26e9);
        check("mute", input_cfg, 7'h09);
        check("ratio_ok", synth_ratio_ok, 1);
    endtask
    task automatic t_masks();
        for (int i = 0; i < 10; i++) wr(atab[i], 16'hffff);
        wr(7'h28, 16'hffff);
        for (int i = 0; i < 10; i++) rd_check(atab[i], mtab[i]);
        rd_check(7'h28, 16'h0000);
        check("alc", alc_cfg, 32'h3_ffff);
        check("pll", pll_cfg, 32'hffff_ffff);
        check("inp", input_cfg, 7'h7f);
        for (int i = 0; i < 10; i++) wr(atab[i], 16'h0000);
        check("inp0", input_cfg, 7'h00);
    endtask
    task automatic t_prescale();
        logic [3:0] rt [4] = '{4'h5, 4'h6, 4'hc, 4'hd};
        for (int p = 0; p < 4; p++) begin
            wr(7'h24, {10'h001, p[1:0], rt[p]});
            @(negedge core_clk);
            check("mult2", synth_prescale.mult2, p == 0);
            check("div", synth_prescale.div_log2, (p == 2) ? 1 : (p == 3) ? 2 : 0);
            check("ok", synth_ratio_ok, rt[p] > 5 && rt[p] < 13);
        end
        @(negedge core_clk);
        reg_wr_en = 1'b1; reg_addr = 7'h25; reg_wdata = 16'h002a;
        @(negedge core_clk);
        reg_addr = 7'h26; reg_wdata = 16'h0155;
        @(negedge core_clk);
        reg_addr = 7'h27; reg_wdata = 16'h00aa;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
        check("frac2", pll_cfg.synth_fraction_ratio, {6'h2a, 9'h155, 9'h0aa});
    endtask
    task automatic t_gain();
        wr(7'h2d, 16'h0000);
        @(negedge core_clk);
        gain_vol_written = 1'b1;
        @(negedge core_clk);
        gain_vol_written = 1'b0;
        check("apply_now", gain_apply, 1);
        wr(7'h2d, 16'h0080);
        gain_vol_written = 1'b1;
        zero_cross_seen = 1'b1;
        @(negedge core_clk);
        gain_vol_written = 1'b0;
        zero_cross_seen = 1'b0;
        repeat (3) begin
            @(negedge core_clk);
            check("apply_wait", gain_apply, 0);
        end
        zero_cross_seen = 1'b1;
        @(negedge core_clk);
        zero_cross_seen = 1'b0;
        check("apply_zc", gain_apply, 1);
        @(negedge core_clk);
        check("apply_end", gain_apply, 0);
    endtask
    // ==========================================================================
    // Clock, timeout and main sequence.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        reset = 1'b1; reg_wr_en = 1'b0; reg_rd_en = 1'b0; reg_addr = 7'h00;
        reg_wdata = 16'h0000; gain_vol_written = 1'b0; zero_cross_seen = 1'b0;
        mismatches = 0; cmp_count = 0; cycles = 0;
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        t_reset_values();
        t_masks();
        t_prescale();
        t_gain();
        conclude();
    end
endmodule

/* File: verilog/codec_alc_pll_input_regs.sv */
/*
 * Control register bank for level control, noise gate, frequency synthesiser,
 * microphone bias and input routing, with the input gain update gate.
 * Assumes a simple synchronous register port fed by the serial control
 * interface, and zero-crossing and gain-write pulses from the analog side.
 */
`timescale 1ns/1ns

module codec_alc_pll_input_regs (
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire logic                     reg_wr_en,
    input  wire logic                     reg_rd_en,
    input  wire codec_regs_pkg::addr_t    reg_addr,
    input  wire logic [15:0]              reg_wdata,
    output logic [15:0]                   reg_rdata,
    output logic                          reg_rd_valid,
    input  wire logic                     gain_vol_written,
    input  wire logic                     zero_cross_seen,
    output codec_regs_pkg::alc_cfg_s      alc_cfg,
    output codec_regs_pkg::pll_cfg_s      pll_cfg,
    output codec_regs_pkg::input_cfg_s    input_cfg,
    output codec_regs_pkg::prescale_s     synth_prescale,
    output logic                          synth_ratio_ok,
    output logic                          gain_apply
);

    // ==========================================================================
    // Address decode.
    function automatic logic [3:0] reg_index(input codec_regs_pkg::addr_t addr);
        logic [3:0] idx;
        idx = 4'(codec_regs_pkg::NUM_REGS);
        for (int i = 0; i < codec_regs_pkg::NUM_REGS; i++) begin
            if (addr == codec_regs_pkg::REG_ADDR[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // ==========================================================================
    // Prescale decode.
    function automatic codec_regs_pkg::prescale_s decode_prescale(input logic [1:0] code);
        codec_regs_pkg::prescale_s p;
        p.mult2    = (code == 2'b00);
        p.div_log2 = (code == 2'b00) ? 2'h0 : 2'(code - 2'b01);
        return p;
    endfunction

    codec_regs_pkg::field_t field_q [codec_regs_pkg::NUM_REGS];
    logic [3:0]             wr_idx;
    logic [3:0]             rd_idx;
    logic                   gain_pending;

    assign wr_idx = reg_index(reg_addr);
    assign rd_idx = reg_index(reg_addr);

    // ==========================================================================
    // Register storage.
    for (genvar g = 0; g < codec_regs_pkg::NUM_REGS; g++) begin : g_regs
        ctrl_field_reg #(
            .MASK        (codec_regs_pkg::REG_MASK[g]),
            .RESET_VALUE (codec_regs_pkg::REG_RESET[g])
        ) u_reg (
            .core_clk  (core_clk),
            .reset     (reset),
            .wr_en     (reg_wr_en && (wr_idx == 4'(g))),
            .wdata     (reg_wdata[8:0]),
            .value_reg (field_q[g])
        );
    end

    // ==========================================================================
    // Read port; unmapped addresses and reserved bits read zero.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd_en) begin
            if (rd_idx < 4'(codec_regs_pkg::NUM_REGS)) begin
                reg_rdata <= {7'h00, field_q[rd_idx]};
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
        end
    end

    // ==========================================================================
    // Level control fields.
    assign alc_cfg.level_target    = field_q[codec_regs_pkg::IDX_LEVEL][3:0];
    assign alc_cfg.level_loop_mode =
        field_q[codec_regs_pkg::IDX_TIMING][codec_regs_pkg::LOOP_MODE_BIT];
    assign alc_cfg.gain_rise_time  =
        field_q[codec_regs_pkg::IDX_TIMING][codec_regs_pkg::RISE_LSB +: 4];
    assign alc_cfg.gain_fall_time  = field_q[codec_regs_pkg::IDX_TIMING][3:0];
    assign alc_cfg.gate_enable     =
        field_q[codec_regs_pkg::IDX_GATE][codec_regs_pkg::GATE_EN_BIT];
    assign alc_cfg.gate_threshold  = field_q[codec_regs_pkg::IDX_GATE][2:0];
    assign alc_cfg.level_loop_zero_cross =
        field_q[codec_regs_pkg::IDX_ALC_ZC][codec_regs_pkg::LOOP_ZC_BIT];

    // ==========================================================================
    // Synthesiser fields.
    assign pll_cfg.synth_power_off =
        field_q[codec_regs_pkg::IDX_PLL][codec_regs_pkg::POWER_OFF_BIT];
    assign pll_cfg.fractional_divide_enable =
        field_q[codec_regs_pkg::IDX_PLL][codec_regs_pkg::FRAC_EN_BIT];
    assign pll_cfg.synth_input_prescale =
        field_q[codec_regs_pkg::IDX_PLL][codec_regs_pkg::PRESCALE_LSB +: 2];
    assign pll_cfg.synth_integer_ratio = field_q[codec_regs_pkg::IDX_PLL][3:0];
    assign pll_cfg.synth_fraction_ratio = {
        field_q[codec_regs_pkg::IDX_FRAC_HI][5:0],
        field_q[codec_regs_pkg::IDX_FRAC_MD],
        field_q[codec_regs_pkg::IDX_FRAC_LO]};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            synth_prescale <= decode_prescale(codec_regs_pkg::REG_RESET[codec_regs_pkg::IDX_PLL]
                                              [codec_regs_pkg::PRESCALE_LSB +: 2]);
        end else begin
            synth_prescale <= decode_prescale(pll_cfg.synth_input_prescale);
        end
    end

    // The analog side relies on software keeping the ratio legal; this flags it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            synth_ratio_ok <= 1'b1;
        end else begin
            synth_ratio_ok <= (pll_cfg.synth_integer_ratio > codec_regs_pkg::RATIO_LOW_EXCL) &&
                              (pll_cfg.synth_integer_ratio < codec_regs_pkg::RATIO_HIGH_EXCL);
        end
    end

    // ==========================================================================
    // Input routing and gain stage fields.
    assign input_cfg.mic_bias_level_select =
        field_q[codec_regs_pkg::IDX_ROUTING][codec_regs_pkg::BIAS_SEL_BIT];
    assign input_cfg.aux_amp_mode =
        field_q[codec_regs_pkg::IDX_ROUTING][codec_regs_pkg::AUX_MODE_BIT];
    assign input_cfg.aux_to_gain_stage =
        field_q[codec_regs_pkg::IDX_ROUTING][codec_regs_pkg::AUX_TO_PGA_BIT];
    assign input_cfg.mic_neg_to_gain_stage =
        field_q[codec_regs_pkg::IDX_ROUTING][codec_regs_pkg::MIC_NEG_BIT];
    assign input_cfg.mic_pos_to_gain_stage =
        field_q[codec_regs_pkg::IDX_ROUTING][codec_regs_pkg::MIC_POS_BIT];
    assign input_cfg.input_gain_zero_cross =
        field_q[codec_regs_pkg::IDX_GAIN][codec_regs_pkg::GAIN_ZC_BIT];
    assign input_cfg.input_gain_mute =
        field_q[codec_regs_pkg::IDX_GAIN][codec_regs_pkg::GAIN_MUTE_BIT];

    gain_zero_cross_gate u_gain_gate (
        .core_clk          (core_clk),
        .reset             (reset),
        .zero_cross_enable (input_cfg.input_gain_zero_cross),
        .gain_written      (gain_vol_written),
        .zero_cross_seen   (zero_cross_seen),
        .pending_reg       (gain_pending),
        .apply_reg         (gain_apply)
    );

    // ==========================================================================
    // Assertions.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    logic wr_timing;
    logic wr_gate;
    logic wr_routing;
    assign wr_timing  = reg_wr_en && (reg_addr == codec_regs_pkg::ALC_MODE_TIMING_ADDR);
    assign wr_gate    = reg_wr_en && (reg_addr == codec_regs_pkg::NOISE_GATE_CTRL_ADDR);
    assign wr_routing = reg_wr_en && (reg_addr == codec_regs_pkg::INPUT_ROUTING_CTRL_ADDR);

    property p_level_reset;
        @(posedge core_clk) disable iff (1'b0) reset |=> alc_cfg.level_target == 4'hb;
    endproperty
    a_level_reset: assert property (p_level_reset)
        else $error("level target reset wrong");

    property p_loop_mode;
        wr_timing |=> alc_cfg.level_loop_mode == $past(reg_wdata[8]);
    endproperty
    a_loop_mode: assert property (p_loop_mode)
        else $error("loop mode not written");

    property p_rise_time;
        @(posedge core_clk) disable iff (1'b0) reset ##1 !reset[*2] |->
            alc_cfg.gain_rise_time == 4'h3 || $past(wr_timing) || $past(wr_timing, 2);
    endproperty
    a_rise_time: assert property (p_rise_time)
        else $error("rise time reset wrong");

    property p_fall_time;
        wr_timing |=> alc_cfg.gain_fall_time == $past(reg_wdata[3:0]) &&
            alc_cfg.gain_rise_time == $past(reg_wdata[7:4]);
    endproperty
    a_fall_time: assert property (p_fall_time)
        else $error("timing fields not written");

    property p_gate;
        wr_gate |=> alc_cfg.gate_enable == $past(reg_wdata[3]) &&
            alc_cfg.gate_threshold == $past(reg_wdata[2:0]);
    endproperty
    a_gate: assert property (p_gate)
        else $error("noise gate fields not written");

    property p_pll_reset;
        @(posedge core_clk) disable iff (1'b0) reset |=> !pll_cfg.synth_power_off &&
            pll_cfg.fractional_divide_enable && pll_cfg.synth_integer_ratio == 4'hc;
    endproperty
    a_pll_reset: assert property (p_pll_reset)
        else $error("synth reset wrong");

    property p_prescale;
        ##1 1'b1 |-> synth_prescale.mult2 == ($past(pll_cfg.synth_input_prescale) == 2'b00) &&
            ($past(pll_cfg.synth_input_prescale) != 2'b11 || synth_prescale.div_log2 == 2'h2);
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("prescale decode wrong");

    property p_ratio_ok;
        pll_cfg.synth_integer_ratio == 4'hd |=> !synth_ratio_ok;
    endproperty
    a_ratio_ok: assert property (p_ratio_ok)
        else $error("ratio 13 not flagged");

    sequence s_frac_writes;
        reg_wr_en && reg_addr == codec_regs_pkg::PLL_FRAC_HIGH_ADDR ##1
        reg_wr_en && reg_addr == codec_regs_pkg::PLL_FRAC_MID_ADDR ##1
        reg_wr_en && reg_addr == codec_regs_pkg::PLL_FRAC_LOW_ADDR;
    endsequence

    property p_fraction;
        s_frac_writes |=> pll_cfg.synth_fraction_ratio ==
            {$past(reg_wdata[5:0], 3), $past(reg_wdata[8:0], 2), $past(reg_wdata[8:0])};
    endproperty
    a_fraction: assert property (p_fraction)
        else $error("fraction not assembled");

    property p_loop_zc_reset;
        @(posedge core_clk) disable iff (1'b0) reset |=> !alc_cfg.level_loop_zero_cross;
    endproperty
    a_loop_zc_reset: assert property (p_loop_zc_reset)
        else $error("loop zc reset wrong");

    property p_routing;
        wr_routing |=> input_cfg.mic_bias_level_select == $past(reg_wdata[8]) &&
            input_cfg.aux_amp_mode == $past(reg_wdata[3]) &&
            input_cfg.aux_to_gain_stage == $past(reg_wdata[2]) &&
            input_cfg.mic_pos_to_gain_stage == $past(reg_wdata[0]);
    endproperty
    a_routing: assert property (p_routing)
        else $error("routing fields not written");

    property p_routing_reset;
        @(posedge core_clk) disable iff (1'b0) reset |=> input_cfg.mic_neg_to_gain_stage &&
            !input_cfg.mic_pos_to_gain_stage && !input_cfg.aux_to_gain_stage;
    endproperty
    a_routing_reset: assert property (p_routing_reset)
        else $error("routing reset wrong");

    property p_gain_now;
        gain_vol_written && !input_cfg.input_gain_zero_cross |=> gain_apply;
    endproperty
    a_gain_now: assert property (p_gain_now)
        else $error("gain not applied at once");

    sequence s_wait_cross;
        gain_vol_written && input_cfg.input_gain_zero_cross && !gain_pending ##1
        !zero_cross_seen && input_cfg.input_gain_zero_cross;
    endsequence

    property p_gain_wait;
        s_wait_cross |=> !gain_apply;
    endproperty
    a_gain_wait: assert property (p_gain_wait)
        else $error("gain applied before cross");

    property p_gain_cross;
        gain_pending && zero_cross_seen |=> gain_apply;
    endproperty
    a_gain_cross: assert property (p_gain_cross)
        else $error("gain not applied at cross");

    property p_mute_reset;
        @(posedge core_clk) disable iff (1'b0) reset |=>
            input_cfg.input_gain_mute && !input_cfg.input_gain_zero_cross;
    endproperty
    a_mute_reset: assert property (p_mute_reset)
        else $error("mute reset wrong");

    property p_unmapped_read;
        reg_rd_en && reg_index(reg_addr) == 4'ha |=> reg_rd_valid && reg_rdata == 16'h0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_reserved_zero;
        reg_rd_valid |-> reg_rdata[15:9] == 7'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits set");

    property p_level_write;
        reg_wr_en && reg_addr == codec_regs_pkg::LEVEL_TARGET_CTRL_ADDR |=>
            alc_cfg.level_target == $past(reg_wdata[3:0]);
    endproperty
    a_level_write: assert property (p_level_write)
        else $error("level target not written");

    property p_pll_write;
        reg_wr_en && reg_addr == codec_regs_pkg::PLL_CTRL_ADDR |=>
            pll_cfg.synth_power_off == $past(reg_wdata[7]) &&
            pll_cfg.fractional_divide_enable == $past(reg_wdata[6]) &&
            pll_cfg.synth_integer_ratio == $past(reg_wdata[3:0]);
    endproperty
    a_pll_write: assert property (p_pll_write)
        else $error("synth control not written");

    property p_prescale_half;
        pll_cfg.synth_input_prescale == 2'b10 |=>
            !synth_prescale.mult2 && synth_prescale.div_log2 == 2'h1;
    endproperty
    a_prescale_half: assert property (p_prescale_half)
        else $error("halving prescale wrong");

    property p_gate_reset;
        @(posedge core_clk) disable iff (1'b0) reset |=>
            !alc_cfg.gate_enable && alc_cfg.gate_threshold == 3'h0 && !alc_cfg.level_loop_mode;
    endproperty
    a_gate_reset: assert property (p_gate_reset)
        else $error("noise gate reset wrong");

endmodule

/* File: verilog/ctrl_field_reg.sv */
/*
 * One control register: masked storage with a reset value.
 * Assumes the write strobe is already decoded for this register.
 */
`timescale 1ns/1ns
module ctrl_field_reg #(
    parameter codec_regs_pkg::field_t MASK        = 9'h1ff,
    parameter codec_regs_pkg::field_t RESET_VALUE = 9'h000
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   wr_en,
    input  wire codec_regs_pkg::field_t wdata,
    output codec_regs_pkg::field_t      value_reg
);

    // ==========================================================================
    // Storage; reserved bits never leave zero.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            value_reg <= RESET_VALUE & MASK;
        end else if (wr_en) begin
            value_reg <= wdata & MASK;
        end
    end

endmodule

/* File: verilog/gain_zero_cross_gate.sv */
/*
 * Decides when a new input gain is applied: at once, or at the first
 * zero crossing after the gain write.
 * Assumes one-cycle pulses for the gain write and the zero crossing.
 */
`timescale 1ns/1ns
module gain_zero_cross_gate (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic zero_cross_enable,
    input  wire logic gain_written,
    input  wire logic zero_cross_seen,
    output logic      pending_reg,
    output logic      apply_reg
);

    // ==========================================================================
    // A later write re-arms the wait; the write wins over the clear.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pending_reg <= 1'b0;
        end else if (gain_written && zero_cross_enable) begin
            pending_reg <= 1'b1;
        end else if (zero_cross_seen || !zero_cross_enable) begin
            pending_reg <= 1'b0;
        end
    end

    // ==========================================================================
    // Apply pulse.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            apply_reg <= 1'b0;
        end else begin
            apply_reg <= (gain_written && !zero_cross_enable) ||
                         (pending_reg && (zero_cross_seen || !zero_cross_enable));
        end
    end

endmodule
